/* File: common/rofm_pkg.sv */
/*
 package of constants for the rail force-on, output level and fault mask registers.
 assumes a register port carrying byte address, write strobe and read data.
*/
package rofm_pkg;
   localparam logic [7:0] ROFM_FORCE_LEVEL_ADDR = 8'ha1;
   localparam logic [7:0] ROFM_FAULT_MASK_ADDR = 8'ha2;
   localparam int ROFM_LVL4_BIT = 7;
   localparam int ROFM_LVL3_BIT = 6;
   localparam int ROFM_LVL2_BIT = 5;
   localparam int ROFM_LVL1_BIT = 4;
   localparam int ROFM_TERM_BIT = 3;
   localparam int ROFM_LOAD_SWITCH_B2_BIT = 2;
   localparam int ROFM_LOAD_SWITCH_B1_BIT = 1;
   localparam int ROFM_LDO_A3_A_BIT = 0;
   localparam int ROFM_LDO_A2_B_MASK_BIT = 7;
   localparam int ROFM_LOAD_SWITCH_A1_MASK_BIT = 6;
   localparam logic [7:0] ROFM_READ_IDLE = 8'h00;
   // output pin modes from factory config
   typedef enum logic [1:0] {
      ROFM_PIN_POWER_GOOD,
      ROFM_PIN_OPEN_DRAIN,
      ROFM_PIN_PUSH_PULL,
      ROFM_PIN_UNUSED
   } rofm_pin_mode_t;
endpackage : rofm_pkg

/* File: verilog/rofm_rail_gate.sv */
/*
 rail enable gate: pin or power-good request, force-on and disable.
 assumes all inputs synchronous to clk.
*/
`timescale 1ns/1ps
module rofm_rail_gate (
   clk,
   rst,
   force_on,
   disable_n,
   pin_request,
   rail_on
);
   input wire logic clk;
   input wire logic rst;
   input wire logic force_on;
   input wire logic disable_n;
   input wire logic pin_request;
   output logic rail_on;
   always_ff @(posedge clk) begin
      if (rst) begin
         rail_on <= 1'b0;
      end else begin
         // disable low wins, then force-on, else pin or power good
         rail_on <= disable_n & (force_on | pin_request);
      end
   end
endmodule : rofm_rail_gate

/* File: verilog/rofm_gpo_pin.sv */
/*
 one general output pin driver from a level bit and its factory mode.
 assumes mode static after reset; open-drain high is released pin.
*/
`timescale 1ns/1ps
module rofm_gpo_pin
   import rofm_pkg::*;
#(
   parameter bit OPEN_DRAIN_ONLY = 1'b0
) (
   clk,
   rst,
   mode,
   level,
   power_good_level,
   pin_out,
   pin_oe
);
   input wire logic clk;
   input wire logic rst;
   input wire rofm_pkg::rofm_pin_mode_t mode;
   input wire logic level;
   input wire logic power_good_level;
   output logic pin_out;
   output logic pin_oe;
   always_ff @(posedge clk) begin
      if (rst) begin
         pin_out <= 1'b0;
         pin_oe <= 1'b0;
      end else begin
         case (mode)
            ROFM_PIN_OPEN_DRAIN: begin
               // low drives, high releases
               pin_out <= 1'b0;
               pin_oe <= ~level;
            end
            ROFM_PIN_PUSH_PULL: begin
               pin_out <= OPEN_DRAIN_ONLY ? power_good_level : level;
               pin_oe <= 1'b1;
            end
            ROFM_PIN_POWER_GOOD: begin
               pin_out <= power_good_level;
               pin_oe <= 1'b1;
            end
            default: begin
               // unused pin ignores the level field
               pin_out <= 1'b0;
               pin_oe <= 1'b0;
            end
         endcase
      end
   end
endmodule : rofm_gpo_pin

/* File: verilog/rofm_regs.sv */
/*
 top: force-on/output level and fault mask registers, rail gating,
 output pin drive and fault shutdown.
 assumes the serial bus slave presents a byte address, write strobe
 and data one cycle, and that factory config values are stable at reset.
*/
`timescale 1ns/1ps
module rofm_regs
   import rofm_pkg::*;
(
   clk,
   rst,
   reg_addr,
   reg_wr,
   reg_wdata,
   reg_rdata,
   otp_force_level,
   otp_fault_mask,
   otp_pin_mode,
   termination_ldo_disable,
   load_switch_b2_disable,
   load_switch_b1_disable,
   ldo_a3_disable,
   rail_pin_request,
   power_good_levels,
   rail_fault,
   termination_ldo_on,
   load_switch_b2_on,
   load_switch_b1_on,
   ldo_a3_a_on,
   gpo_out,
   gpo_oe,
   shutdown_req
);
   input wire logic clk;
   input wire logic rst;
   input wire logic [7:0] reg_addr;
   input wire logic reg_wr;
   input wire logic [7:0] reg_wdata;
   output logic [7:0] reg_rdata;
   input wire logic [7:0] otp_force_level;
   input wire logic [7:0] otp_fault_mask;
   input wire rofm_pkg::rofm_pin_mode_t [3:0] otp_pin_mode;
   input wire logic termination_ldo_disable;
   input wire logic load_switch_b2_disable;
   input wire logic load_switch_b1_disable;
   input wire logic ldo_a3_disable;
   input wire logic [3:0] rail_pin_request;
   input wire logic [3:0] power_good_levels;
   input wire logic [7:0] rail_fault;
   output logic termination_ldo_on;
   output logic load_switch_b2_on;
   output logic load_switch_b1_on;
   output logic ldo_a3_a_on;
   output logic [3:0] gpo_out;
   output logic [3:0] gpo_oe;
   output logic shutdown_req;

   logic [7:0] force_level_q;
   logic [7:0] fault_mask_q;
   logic load_q;
   logic [3:0] level_bits;
   logic [3:0] force_bits;
   logic [3:0] disable_bits;
   logic [3:0] rail_on;

   // reset value caught on the first clock after release
   always_ff @(posedge clk) begin
      if (rst) begin
         load_q <= 1'b1;
      end else begin
         load_q <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         force_level_q <= 8'h00;
      end else if (load_q) begin
         force_level_q <= otp_force_level;
      end else if (reg_wr && reg_addr == ROFM_FORCE_LEVEL_ADDR) begin
         force_level_q <= reg_wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         fault_mask_q <= 8'h00;
      end else if (load_q) begin
         fault_mask_q <= otp_fault_mask;
      end else if (reg_wr && reg_addr == ROFM_FAULT_MASK_ADDR) begin
         fault_mask_q <= reg_wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         reg_rdata <= ROFM_READ_IDLE;
      end else begin
         case (reg_addr)
            ROFM_FORCE_LEVEL_ADDR: reg_rdata <= force_level_q;
            ROFM_FAULT_MASK_ADDR: reg_rdata <= fault_mask_q;
            default: reg_rdata <= ROFM_READ_IDLE;
         endcase
      end
   end

   // unmasked fault requests shutdown
   always_ff @(posedge clk) begin
      if (rst) begin
         shutdown_req <= 1'b0;
      end else begin
         shutdown_req <= |(rail_fault & ~fault_mask_q);
      end
   end

   assign force_bits = {force_level_q[ROFM_TERM_BIT], force_level_q[ROFM_LOAD_SWITCH_B2_BIT],
                        force_level_q[ROFM_LOAD_SWITCH_B1_BIT], force_level_q[ROFM_LDO_A3_A_BIT]};
   assign disable_bits = {termination_ldo_disable, load_switch_b2_disable,
                          load_switch_b1_disable, ldo_a3_disable};
   assign level_bits = {force_level_q[ROFM_LVL4_BIT], force_level_q[ROFM_LVL3_BIT],
                        force_level_q[ROFM_LVL2_BIT], force_level_q[ROFM_LVL1_BIT]};

   // index 3 termination ldo, 2 switch b2, 1 switch b1, 0 ldo a3
   for (genvar i = 0; i < 4; i++) begin : g_rail
      rofm_rail_gate u_gate (
         .clk(clk),
         .rst(rst),
         .force_on(force_bits[i]),
         .disable_n(disable_bits[i]),
         .pin_request(rail_pin_request[i]),
         .rail_on(rail_on[i])
      );
   end
   assign termination_ldo_on = rail_on[3];
   assign load_switch_b2_on = rail_on[2];
   assign load_switch_b1_on = rail_on[1];
   assign ldo_a3_a_on = rail_on[0];

   for (genvar g = 0; g < 4; g++) begin : g_gpo
      rofm_gpo_pin #(
         .OPEN_DRAIN_ONLY(g == 3)
      ) u_pin (
         .clk(clk),
         .rst(rst),
         .mode(otp_pin_mode[g]),
         .level(level_bits[g]),
         .power_good_level(power_good_levels[g]),
         .pin_out(gpo_out[g]),
         .pin_oe(gpo_oe[g])
      );
   end
endmodule : rofm_regs

/* File: testbench/rofm_monitor.sv */
/*
 checker on the ports of rofm_regs.
 assumes one clock, sync active-high reset; bound below.
*/
`timescale 1ns/1ps
module rofm_monitor
   import rofm_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire rofm_pkg::rofm_pin_mode_t [3:0] otp_pin_mode,
   input wire logic termination_ldo_disable,
   input wire logic ldo_a3_disable,
   input wire logic [3:0] rail_pin_request,
   input wire logic [7:0] rail_fault,
   input wire logic termination_ldo_on,
   input wire logic ldo_a3_a_on,
   input wire logic [3:0] gpo_out,
   input wire logic [3:0] gpo_oe,
   input wire logic shutdown_req
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_wr_a1;
      reg_wr && reg_addr == 8'ha1 && !$past(rst);
   endsequence
   a_wr_readback: assert property (s_wr_a1 ##1 (reg_addr == 8'ha1 && !reg_wr) |=>
      reg_rdata == $past(reg_wdata, 2)) else $error("readback differs from write");
   a_unmapped_zero: assert property (reg_addr != 8'ha1 && reg_addr != 8'ha2 |=>
      reg_rdata == 8'h00) else $error("unmapped read not zero");
   a_term_off: assert property (!termination_ldo_disable |=> !termination_ldo_on)
      else $error("termination ldo on while disabled");
   a_term_pin: assert property (termination_ldo_disable && rail_pin_request[3] |=>
      termination_ldo_on) else $error("termination ldo ignores pin request");
   a_a3_off: assert property (!ldo_a3_disable |=> !ldo_a3_a_on)
      else $error("ldo a3 on while disabled");
   a_fault_none: assert property (rail_fault == 8'h00 |=> !shutdown_req)
      else $error("shutdown without fault");
   a_unused_idle: assert property (otp_pin_mode[0] == ROFM_PIN_UNUSED |=> !gpo_oe[0])
      else $error("unused pin driven");
   a_od_low: assert property (otp_pin_mode[1] == ROFM_PIN_OPEN_DRAIN |=> !gpo_out[1])
      else $error("open-drain pin drives high");
endmodule : rofm_monitor
bind rofm_regs rofm_monitor u_mon (.clk, .rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata,
   .otp_pin_mode, .termination_ldo_disable, .ldo_a3_disable, .rail_pin_request, .rail_fault,
   .termination_ldo_on, .ldo_a3_a_on, .gpo_out, .gpo_oe, .shutdown_req);

/* File: testbench/rofm_host.sv */
/*
 host model driving the register port.
 assumes clk from the bench; one request at a time.
*/
`timescale 1ns/1ps
module rofm_host (
   input wire logic clk,
   output logic [7:0] reg_addr,
   output logic reg_wr,
   output logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata
);
   initial begin
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_wdata = 8'h00;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wr <= 1'b1;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_wdata <= ~d;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      repeat (2) @(posedge clk);
      @(negedge clk);
      d = reg_rdata;
   endtask : rd
endmodule : rofm_host

/* File: testbench/test_rofm_regs.sv */
/*
 self-checking bench for rofm_regs.
 assumes rofm_host drives the register port.
*/
`timescale 1ns/1ps
module test_rofm_regs;
   import rofm_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic reg_wr, shut;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, rd;
   logic [7:0] fault = 8'h00;
   logic [3:0] dis = 4'hf, req = 4'h0, on, gout, goe;
   logic [3:0] pg = 4'h0;
   logic [7:0] vals [2] = '{8'ha5, 8'h5a};
   logic [7:0] pins [2] = '{8'h04, 8'h4e};
   rofm_pin_mode_t [3:0] mode = {ROFM_PIN_OPEN_DRAIN, ROFM_PIN_PUSH_PULL,
      ROFM_PIN_OPEN_DRAIN, ROFM_PIN_UNUSED};
   int err_count = 0;
   int num_checks = 0;
   always #2 clk = ~clk;
   rofm_host host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata));
   rofm_regs DUT (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .otp_force_level(8'h10),
      .otp_fault_mask(8'hc0), .otp_pin_mode(mode), .termination_ldo_disable(dis[3]),
      .load_switch_b2_disable(dis[2]), .load_switch_b1_disable(dis[1]),
      .ldo_a3_disable(dis[0]), .rail_pin_request(req), .power_good_levels(pg),
      .rail_fault(fault), .termination_ldo_on(on[3]), .load_switch_b2_on(on[2]),
      .load_switch_b1_on(on[1]), .ldo_a3_a_on(on[0]), .gpo_out(gout), .gpo_oe(goe),
      .shutdown_req(shut));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic settle;
      repeat (2) @(posedge clk);
      @(negedge clk);
   endtask : settle
   task automatic flt(input logic [7:0] m, input logic [7:0] f, input logic e);
      host.wr(8'ha2, m);
      @(posedge clk);
      fault <= f;
      settle();
      chk({7'h00, shut}, {7'h00, e});
   endtask : flt
   task automatic stop_test;
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : stop_test
   initial begin
      #20000;
      err_count++;
      stop_test();
   end
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      host.rd(8'ha1, rd);
      chk(rd, 8'h10);
      host.rd(8'ha2, rd);
      chk(rd, 8'hc0);
      host.rd(8'h9f, rd);
      chk(rd, 8'h00);
      for (int i = 0; i < 2; i++) begin
         host.wr(8'ha1, vals[i]);
         host.rd(8'ha1, rd);
         chk(rd, vals[i]);
         chk({gout, goe}, pins[i]);
         chk({4'h0, on}, {4'h0, vals[i][3:0]});
         @(posedge clk);
         dis <= 4'h0;
         settle();
         chk({4'h0, on}, 8'h00);
         @(posedge clk);
         dis <= 4'hf;
      end
      // output 4 push-pull shows power good, pin 0 in power-good mode
      @(posedge clk);
      mode <= {ROFM_PIN_PUSH_PULL, ROFM_PIN_PUSH_PULL, ROFM_PIN_OPEN_DRAIN,
         ROFM_PIN_POWER_GOOD};
      pg <= 4'h9;
      settle();
      chk({gout, goe}, 8'hdf);
      host.wr(8'ha1, 8'h00);
      @(posedge clk);
      req <= 4'hf;
      settle();
      chk({4'h0, on}, 8'h0f);
      flt(8'h0f, 8'h0f, 1'b0);
      flt(8'h0f, 8'h10, 1'b1);
      flt(8'h80, 8'h80, 1'b0);
      flt(8'h80, 8'h40, 1'b1);
      stop_test();
   end
endmodule : test_rofm_regs
